// ### hw/wdog_pkg.sv
// package: timing constants and state encoding for the window watchdog supervisor
package wdog_pkg;
    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned RESET_DELAY_MS  = 200;   // reset delay period, typical
    localparam int unsigned SELECT_EVAL_US  = 381;   // select_evaluation_period
    localparam int unsigned MIN_PULSE_US    = 1;     // least pulse on manual reset / enable
    localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned SELECT_EVAL_CYC = SELECT_EVAL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned MIN_PULSE_CYC   = MIN_PULSE_US * (CLK_HZ / 1_000_000);
    // preset window bounds used when no capacitor is fitted (plain defaults)
    localparam int unsigned PRESET_LOWER_CYC = 100_000;
    localparam int unsigned PRESET_UPPER_CYC = 1_000_000;
    localparam int unsigned CNT_W            = 32;

    // ************************************************************
    // watchdog states
    // ************************************************************
    typedef enum logic [1:0] {
        ST_INIT  = 2'b00,
        ST_WATCH = 2'b01,
        ST_FAULT = 2'b10
    } wd_state_e;
endpackage : wdog_pkg

// ### hw/pin_sync.sv
// three-stage pin synchroniser with agreement of the last two stages
module pin_sync (
    input  wire logic clk,     // system clock
    input  wire logic resetn,  // synchronous reset, active low
    input  wire logic pin_in,  // raw asynchronous pin
    input  wire logic rst_val, // level held during reset
    output logic      level    // filtered level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // first stage feeds only the second; a change counts once stages two and three agree
    // reset loads the idle level of the pin, so no false edge follows reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_q  <= rst_val;
            s2_q  <= rst_val;
            s3_q  <= rst_val;
            level <= rst_val;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level <= s3_q;
            end
        end
    end
endmodule // pin_sync

// ### hw/window_watchdog_supervisor.sv
// window watchdog with manual-reset delay and open-drain fault output
module window_watchdog_supervisor
    import wdog_pkg::*;
#(
    parameter int unsigned RESET_DELAY = RESET_DELAY_CYC,  // reset delay in cycles
    parameter int unsigned SELECT_EVAL = SELECT_EVAL_CYC,  // select evaluation in cycles
    parameter int unsigned LOWER_PRE   = PRESET_LOWER_CYC, // preset lower bound
    parameter int unsigned UPPER_PRE   = PRESET_UPPER_CYC, // preset upper bound
    parameter int unsigned LOWER_CAP   = PRESET_LOWER_CYC, // lower bound, capacitor mode
    parameter int unsigned UPPER_CAP   = 2 * PRESET_UPPER_CYC // upper bound, capacitor mode
) (
    input  wire logic clk,                   // 100 MHz clock
    input  wire logic resetn,                // synchronous reset, active low
    input  wire logic watchdog_enable_input, // pin, low disables watchdog
    input  wire logic watchdog_kick_input,   // pin, falling edge kicks
    input  wire logic manual_reset_input,    // pin, low forces reset
    input  wire logic timeout_select_pin,    // pin, high selects preset timeouts
    output logic      reset_out_n,           // system reset, low = reset
    output logic      wdo_o,                 // fault pin output value, always 0
    output logic      wdo_oe                 // fault pin enable, high = pull low
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic en_s;
    logic kick_s;
    logic mr_s;
    logic sel_s;

    pin_sync u_en   (.clk(clk), .resetn(resetn), .pin_in(watchdog_enable_input),
                     .rst_val(1'b1), .level(en_s));
    pin_sync u_kick (.clk(clk), .resetn(resetn), .pin_in(watchdog_kick_input),
                     .rst_val(1'b1), .level(kick_s));
    pin_sync u_mr   (.clk(clk), .resetn(resetn), .pin_in(manual_reset_input),
                     .rst_val(1'b1), .level(mr_s));
    pin_sync u_sel  (.clk(clk), .resetn(resetn), .pin_in(timeout_select_pin),
                     .rst_val(1'b1), .level(sel_s));

    // ************************************************************
    // reset output with delay
    // ************************************************************
    logic [CNT_W-1:0] rst_cnt_q;

    // reset stays low while manual reset is low and for the delay after release
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rst_cnt_q   <= '0;
            reset_out_n <= 1'b0;
        end else if (!mr_s) begin
            rst_cnt_q   <= '0;
            reset_out_n <= 1'b0;
        end else if (!reset_out_n) begin
            if (rst_cnt_q == CNT_W'(RESET_DELAY - 1)) begin
                reset_out_n <= 1'b1;
            end else begin
                rst_cnt_q <= rst_cnt_q + 1'b1;
            end
        end
    end

    // ************************************************************
    // kick edge detect
    // ************************************************************
    logic kick_d1_q;
    logic kick_fall;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            kick_d1_q <= 1'b1;
        end else begin
            kick_d1_q <= kick_s;
        end
    end
    assign kick_fall = kick_d1_q & ~kick_s;

    // ************************************************************
    // watchdog state machine
    // ************************************************************
    wd_state_e        state_q;
    logic [CNT_W-1:0] win_cnt_q;
    logic             sel_preset_q;
    logic [CNT_W-1:0] lower_b;
    logic [CNT_W-1:0] upper_b;

    // window bounds picked from the sampled select level
    assign lower_b = sel_preset_q ? CNT_W'(LOWER_PRE) : CNT_W'(LOWER_CAP);
    assign upper_b = sel_preset_q ? CNT_W'(UPPER_PRE) : CNT_W'(UPPER_CAP);

    // the select pin is sampled once after resetn, so a later change needs resetn, not a manual reset, to take effect
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q      <= ST_INIT;
            win_cnt_q    <= '0;
            sel_preset_q <= 1'b1;
            wdo_oe       <= 1'b0;
        end else if (!reset_out_n || !mr_s) begin
            // reset low: fault released, window restarts afterwards
            // manual reset drops the fault on the same edge as the reset output, never later
            wdo_oe    <= 1'b0;
            win_cnt_q <= '0;
            if (state_q != ST_INIT) begin
                state_q <= ST_WATCH;
            end
        end else begin
            unique case (state_q)
                ST_INIT: begin
                    if (win_cnt_q == CNT_W'(SELECT_EVAL - 1)) begin
                        sel_preset_q <= sel_s;
                        win_cnt_q    <= '0;
                        state_q      <= ST_WATCH;
                    end else begin
                        win_cnt_q <= win_cnt_q + 1'b1;
                    end
                end
                ST_WATCH: begin
                    if (!en_s) begin
                        win_cnt_q <= '0;
                    end else if (kick_fall && win_cnt_q < lower_b) begin
                        state_q   <= ST_FAULT;             // early kick
                        wdo_oe    <= 1'b1;
                        win_cnt_q <= '0;
                    end else if (kick_fall) begin
                        win_cnt_q <= '0;                   // valid kick
                    end else if (win_cnt_q >= upper_b - 1'b1) begin
                        state_q   <= ST_FAULT;             // no kick in time
                        wdo_oe    <= 1'b1;
                        win_cnt_q <= '0;
                    end else begin
                        win_cnt_q <= win_cnt_q + 1'b1;
                    end
                end
                ST_FAULT: begin
                    // kicks ignored while the fault is shown
                    if (win_cnt_q == CNT_W'(RESET_DELAY - 1)) begin
                        wdo_oe    <= 1'b0;
                        win_cnt_q <= '0;
                        state_q   <= ST_WATCH;
                    end else begin
                        win_cnt_q <= win_cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q   <= ST_WATCH;
                    win_cnt_q <= '0;
                    wdo_oe    <= 1'b0;
                end
            endcase
        end
    end

    // open drain: value is always low, only the enable moves
    always_ff @(posedge clk) begin
        wdo_o <= 1'b0;
    end

    // ************************************************************
    // assertions
    // ************************************************************
    fault_needs_reset_a: assert property (@(posedge clk) disable iff (!resetn)
        wdo_oe |-> reset_out_n)
        else $error("fault asserted while reset output low");

    reset_drops_fault_a: assert property (@(posedge clk) disable iff (!resetn)
        !reset_out_n |=> !wdo_oe)
        else $error("fault not released after reset low");

    disable_no_fault_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_WATCH && !en_s && !wdo_oe) |=> !wdo_oe)
        else $error("fault raised while disabled");

    fault_enter_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_FAULT) |-> wdo_oe || !reset_out_n || win_cnt_q == '0)
        else $error("fault state without driven fault output");

    fault_release_a: assert property (@(posedge clk) disable iff (!resetn)
        $fell(wdo_oe) |-> !$past(reset_out_n) || !reset_out_n
            || $past(win_cnt_q) == CNT_W'(RESET_DELAY - 1))
        else $error("fault released early");

    mr_forces_reset_a: assert property (@(posedge clk) disable iff (!resetn)
        !mr_s |=> !reset_out_n)
        else $error("manual reset did not force reset");

    reset_delay_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(reset_out_n) |-> $past(rst_cnt_q) == CNT_W'(RESET_DELAY - 1))
        else $error("reset output released before the delay");

    disable_holds_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_WATCH && !en_s) |=> win_cnt_q == '0)
        else $error("window ran while watchdog disabled");

    kick_restart_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_WATCH && reset_out_n && en_s && kick_fall) |=> win_cnt_q == '0)
        else $error("valid kick did not restart window");

    early_kick_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_WATCH && reset_out_n && mr_s && en_s && kick_fall
            && win_cnt_q < lower_b) |=> wdo_oe)
        else $error("early kick not treated as timeout");

    fault_ignores_kick_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_FAULT && reset_out_n && win_cnt_q != CNT_W'(RESET_DELAY - 1))
            |=> state_q == ST_FAULT || !reset_out_n)
        else $error("kick acted during fault");

    select_sample_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_INIT && reset_out_n && mr_s
            && win_cnt_q == CNT_W'(SELECT_EVAL - 1))
            |=> sel_preset_q == $past(sel_s))
        else $error("select not sampled at end of evaluation");
endmodule // window_watchdog_supervisor

// ### testbench/host_model.sv
// host model: services the watchdog kick pin on request from the bench
module host_model (
    input  wire logic clk,      // system clock
    input  wire logic do_kick,  // request for one kick, one cycle
    output logic      kick_pin  // watchdog kick pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] low_cnt_q;  // cycles left with the pin low
    logic       req_q;      // kick request taken at the rising edge

    // ************************************************************
    // kick pulse generator
    // ************************************************************
    // pin always driven to a level, never floating, disabled or not
    initial kick_pin = 1'b1;
    initial req_q = 1'b0;
    // the request is taken at the rising edge, where the bench holds it steady
    always @(posedge clk) begin
        req_q <= do_kick;
    end
    // falling edge starts the kick; held low long enough for the synchroniser
    always @(negedge clk) begin
        if (req_q) begin
            kick_pin  <= 1'b0;
            low_cnt_q <= 4'h8;
        end else if (low_cnt_q != 4'h0) begin
            low_cnt_q <= low_cnt_q - 4'h1;
            if (low_cnt_q == 4'h1) kick_pin <= 1'b1;
        end
    end
    initial low_cnt_q = 4'h0;
endmodule // host_model

// ### testbench/window_watchdog_supervisor_tb.sv
// testbench: window watchdog supervisor with shortened counts against a host model
module window_watchdog_supervisor_tb
    import wdog_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RD = 50;   // reset delay in cycles
    localparam int SE = 10;   // select evaluation in cycles
    localparam int UP = 100;  // preset upper bound
    localparam int UC = 200;  // capacitor upper bound
    logic clk = 1'b0, resetn = 1'b0, en = 1'b1, mr = 1'b1, sel = 1'b1, do_kick = 1'b0;
    logic kick, reset_out_n, wdo_o, wdo_oe;
    int   mismatches = 0, compares = 0, cycles = 0, n;

    always #5 clk = ~clk;

    window_watchdog_supervisor #(.RESET_DELAY(RD), .SELECT_EVAL(SE), .LOWER_PRE(20),
        .UPPER_PRE(UP), .LOWER_CAP(20), .UPPER_CAP(UC)) dut_u (
        .clk(clk), .resetn(resetn), .watchdog_enable_input(en),
        .watchdog_kick_input(kick), .manual_reset_input(mr), .timeout_select_pin(sel),
        .reset_out_n(reset_out_n), .wdo_o(wdo_o), .wdo_oe(wdo_oe));

    host_model host_u (.clk(clk), .do_kick(do_kick), .kick_pin(kick));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string what, input logic exp_v, input logic got);
        compares++;
        if (got !== exp_v) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp_v, got);
        end
    endtask
    // bounded wait for reset_out_n (pick 0) or wdo_oe (pick 1) to reach a level
    task automatic wait_lvl(input bit pick, input logic lvl, input int lim, output int k);
        k = 0;
        while (((pick ? wdo_oe : reset_out_n) !== lvl) && k < lim) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic kick_once();
        do_kick = 1'b1;
        @(negedge clk);
        do_kick = 1'b0;
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_power_up();
        wait_cyc(40);
        check("reset held", 1'b0, reset_out_n);
        check("no fault in reset", 1'b0, wdo_oe);
        wait_lvl(0, 1'b1, 40, n);
        check("reset released", 1'b1, reset_out_n);
        check("output value", 1'b0, wdo_o);
        $display("test power_up done");
    endtask
    task automatic t_timeout();
        wait_lvl(1, 1'b1, SE + UP + 20, n);
        check("fault on no kick", 1'b1, wdo_oe);
        check("fault not early", 1'b1, logic'(n >= UP));
        wait_lvl(1, 1'b0, RD + 10, n);
        check("fault released", 1'b0, wdo_oe);
        check("fault length", 1'b1, logic'(n >= RD - 2));
        $display("test timeout done");
    endtask
    task automatic t_good_kicks();
        for (int i = 0; i < 5; i++) begin
            wait_cyc(42);
            kick_once();
            wait_cyc(8);
            check("no fault on good kick", 1'b0, wdo_oe);
        end
        $display("test good_kicks done");
    endtask
    // early kick faults; a kick during the fault must not shorten or restart it
    task automatic t_early_kick();
        wait_cyc(6);
        kick_once();
        wait_lvl(1, 1'b1, 20, n);
        check("fault on early kick", 1'b1, wdo_oe);
        wait_cyc(10);
        kick_once();
        wait_lvl(1, 1'b0, RD, n);
        check("kick ignored in fault", 1'b1, logic'(n >= RD - 16));
        check("fault not restarted by kick", 1'b0, wdo_oe);
        $display("test early_kick done");
    endtask
    task automatic t_disable();
        en = 1'b0; // held far longer than the least pulse
        wait_cyc(120);
        kick_once();
        wait_cyc(6);
        kick_once();
        wait_lvl(1, 1'b1, 300, n);
        check("disabled no fault", 1'b0, wdo_oe);
        en = 1'b1;
        // only the synchroniser delay, so the next kick falls early in the fresh window
        wait_cyc(8);
        $display("test disable done");
    endtask
    task automatic t_manual_reset();
        kick_once();
        wait_cyc(6);
        kick_once();
        wait_lvl(1, 1'b1, 20, n);
        check("fault before reset", 1'b1, wdo_oe);
        mr = 1'b0; // held only a little longer than the least pulse
        wait_lvl(0, 1'b0, 12, n);
        wait_cyc(1);
        check("manual reset", 1'b0, reset_out_n);
        check("fault freed by reset", 1'b0, wdo_oe);
        wait_cyc(120);
        mr = 1'b1;
        wait_lvl(0, 1'b1, RD + 12, n);
        check("reset after delay", 1'b1, reset_out_n);
        check("reset delay length", 1'b1, logic'(n >= RD));
        $display("test manual_reset done");
    endtask
    // mid-run reset with the select pin low: the longer capacitor window must apply
    task automatic t_select_cap();
        sel    = 1'b0;
        resetn = 1'b0;
        wait_cyc(16);
        resetn = 1'b1;
        wait_cyc(2);
        check("reset low after reset", 1'b0, reset_out_n);
        check("no fault after reset", 1'b0, wdo_oe);
        wait_lvl(0, 1'b1, RD + 10, n);
        check("reset released again", 1'b1, reset_out_n);
        wait_lvl(1, 1'b1, SE + UC + 20, n);
        check("fault on capacitor window", 1'b1, wdo_oe);
        check("capacitor window length", 1'b1, logic'(n >= UC));
        $display("test select_cap done");
    endtask

    // ************************************************************
    // main sequence and hang guard
    // ************************************************************
    initial begin
        wait_cyc(16);
        resetn = 1'b1;
        t_power_up();
        t_timeout();
        t_good_kicks();
        t_early_kick();
        t_disable();
        t_manual_reset();
        t_select_cap();
        wrap_up();
    end
    // a hang counts against the run; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
endmodule // window_watchdog_supervisor_tb
